// File: rtl/vdc_pkg.sv
// Constants, types and decode helpers for the oscillator divider and calibration control
// ********************
// ********************
package vdc_pkg;
   // ********************
   // Register word indices (byte address is four times the index)
   // ********************
   localparam logic [8:0] IDX_UPDATE = 9'h00f;
   localparam logic [8:0] IDX_STATUS = 9'h020;
   localparam logic [8:0] IDX_CONTROL = 9'h100;
   localparam logic [8:0] IDX_LOOP = 9'h101;
   localparam logic [8:0] IDX_FB_INT = 9'h107;
   localparam logic [8:0] IDX_FB_AUX = 9'h108;
   localparam logic [8:0] IDX_PD_RESET = 9'h120;
   localparam logic [8:0] IDX_PD_RATIO = 9'h121;
   localparam logic [8:0] IDX_CH_SRC = 9'h122;
   // ********************
   // Fields and codes
   // ********************
   localparam int CTRL_CAL_BIT = 3;
   localparam int STAT_BUSY_BIT = 2;
   localparam int PDR_A_BIT = 0;
   localparam int PDR_B_BIT = 4;
   localparam int LOOP_LSB = 1;
   localparam logic [7:0] UPDATE_GO = 8'h01;
   localparam logic [1:0] LOOP_ZERO = 2'h0;
   localparam logic [1:0] LOOP_ONE = 2'h1;
   localparam logic [1:0] LOOP_TWO = 2'h2;
   // ********************
   // Reset values
   // ********************
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] LOOP_RST = 8'h00;
   localparam logic [7:0] FB_INT_RST = 8'h32;
   localparam logic [11:0] FB_AUX_RST = 12'h004;
   localparam logic [7:0] PD_RESET_RST = 8'h00;
   localparam logic [7:0] PD_RATIO_RST = 8'h44;
   localparam logic [1:0] CH_SRC_RST = 2'h0;
   // ********************
   // Calibration figures
   // ********************
   localparam int unsigned NUM_BANDS = 256;
   localparam logic [7:0] BAND_MID = 8'h80;
   localparam int unsigned CAL_PFD_CYCLES = 98500;
   localparam logic [19:0] UNGATED_MIN_TOTAL = 20'h00200;
   localparam logic [3:0] RATIO_MIN = 4'h2;
   localparam logic [3:0] RATIO_MAX = 4'hb;

   typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_REF, CAL_RUN} vdc_cal_state_t;

   // Codes outside 2..11 power the divider down
   function automatic logic ratio_active(input logic [3:0] ratio);
      return (ratio >= RATIO_MIN) && (ratio <= RATIO_MAX);
   endfunction
endpackage

// File: rtl/vdc_post_divider.sv
// One post-oscillator divider with power-down decode and synchronous reset
`timescale 1ns/1ns
`default_nettype none
module vdc_post_divider (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Oscillator side
   input wire logic oscTick,
   input wire logic syncReset,
   input wire logic [3:0] ratio,
   // Divided side
   output logic divTick,
   output logic powered
);
   logic [3:0] count_ff;
   logic on;

   assign on = vdc_pkg::ratio_active(ratio);

   always_ff @(posedge clock) begin
      if (rst || syncReset || !on) begin
         count_ff <= 4'h0;
      end else if (oscTick) begin
         count_ff <= (count_ff == ratio - 4'h1) ? 4'h0 : count_ff + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || syncReset || !on) begin
         divTick <= 1'b0;
      end else begin
         divTick <= oscTick && (count_ff == ratio - 4'h1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         powered <= 1'b0;
      end else begin
         powered <= on;
      end
   end

   chk_powerdown_silent: assert property (@(posedge clock) disable iff (rst)
      !vdc_pkg::ratio_active(ratio) |=> !divTick && !powered)
      else $error("Powered-down divider still ticks");
   chk_reset_silent: assert property (@(posedge clock) disable iff (rst)
      syncReset |=> !divTick && count_ff == 4'h0)
      else $error("Divider runs while held in reset");
endmodule // vdc_post_divider
`default_nettype wire

// File: rtl/vdc_band_search.sv
// Successive-approximation band search paced by phase-detector ticks
`timescale 1ns/1ns
`default_nettype none
module vdc_band_search #(
   parameter int unsigned CAL_CYCLES = vdc_pkg::CAL_PFD_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic pfdTick,
   input wire logic fbFaster,
   // Result
   output logic [7:0] band,
   output logic done
);
   // Eight trials, one per band bit, share the calibration span
   localparam int unsigned STEP = CAL_CYCLES / 8;
   localparam int unsigned CW = $clog2(STEP + 1);

   if (CAL_CYCLES < 16) begin : g_bad_len
      $error("CAL_CYCLES too small for eight trials");
   end

   logic active_ff;
   logic [CW-1:0] stepCnt_ff;
   logic [2:0] bitIdx_ff;
   logic stepEnd;
   logic [7:0] nxt_band;

   assign stepEnd = active_ff && pfdTick && (stepCnt_ff == CW'(STEP - 1));

   always_comb begin
      nxt_band = band;
      if (fbFaster) begin
         nxt_band[bitIdx_ff] = 1'b0;
      end
      if (bitIdx_ff != 3'h0) begin
         nxt_band[bitIdx_ff - 3'h1] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         active_ff <= 1'b0;
      end else if (start) begin
         active_ff <= 1'b1;
      end else if (stepEnd && bitIdx_ff == 3'h0) begin
         active_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || start || stepEnd) begin
         stepCnt_ff <= '0;
      end else if (active_ff && pfdTick) begin
         stepCnt_ff <= stepCnt_ff + CW'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst || start) begin
         bitIdx_ff <= 3'h7;
         band <= vdc_pkg::BAND_MID;
      end else if (stepEnd) begin
         bitIdx_ff <= bitIdx_ff - 3'h1;
         band <= nxt_band;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= stepEnd && (bitIdx_ff == 3'h0);
      end
   end

   chk_start_mid: assert property (@(posedge clock) disable iff (rst)
      start |=> band == 8'h80 && active_ff)
      else $error("Band search did not start at mid band");
   chk_step_span: assert property (@(posedge clock) disable iff (rst)
      active_ff && pfdTick && !stepEnd && !start |=> stepCnt_ff == $past(stepCnt_ff) + CW'(1))
      else $error("Trial counter skipped a phase-detector tick");
endmodule // vdc_band_search
`default_nettype wire

// File: rtl/vdc_cal_ctrl.sv
// Oscillator divider and band calibration controller with Avalon-MM registers
`timescale 1ns/1ns
`default_nettype none
module vdc_cal_ctrl #(
   parameter int unsigned CAL_CYCLES = vdc_pkg::CAL_PFD_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Oscillator and reference status
   input wire logic oscTick,
   input wire logic pfdTick,
   input wire logic refEdge,
   input wire logic refLost,
   input wire logic fbFaster,
   // Device events
   input wire logic presetLoadDone,
   input wire logic pllReset,
   // Oscillator band and loop
   output logic [7:0] band,
   output logic [1:0] loopMode,
   output logic calFbCascade,
   output logic calBusy,
   // Post dividers and distribution
   output logic divATick,
   output logic divBTick,
   output logic divAOn,
   output logic divBOn,
   output logic [3:0] chanTick,
   output logic zdTick,
   output logic chanSyncHold
);
   // ********************
   // Bus slave
   // ********************
   logic ack_ff;
   logic [8:0] idx;
   logic aligned;
   logic wrAccept;
   logic commit;
   logic [7:0] rdByte;

   assign idx = avs_address[10:2];
   assign aligned = (avs_address[1:0] == 2'h0);
   // One wait state on every access keeps read data registered
   assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
   assign wrAccept = avs_write && ack_ff && aligned && avs_byteenable[0];
   assign commit = wrAccept && idx == vdc_pkg::IDX_UPDATE
      && avs_writedata[7:0] == vdc_pkg::UPDATE_GO;

   always_ff @(posedge clock) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read || avs_write) && !ack_ff;
      end
   end

   // ********************
   // Staged and active registers
   // ********************
   logic [7:0] ctrlSh_ff;
   logic [7:0] loopSh_ff;
   logic [7:0] fbIntSh_ff;
   logic [11:0] fbAuxSh_ff;
   logic [7:0] pdRstSh_ff;
   logic [7:0] pdRatioSh_ff;
   logic [1:0] chSrcSh_ff;
   logic [7:0] ctrlAct_ff;
   logic [1:0] loopAct_ff;
   logic [7:0] fbIntAct_ff;
   logic [11:0] fbAuxAct_ff;
   logic [7:0] pdRstAct_ff;
   logic [7:0] pdRatioAct_ff;
   logic [1:0] chSrcAct_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrlSh_ff <= vdc_pkg::CONTROL_RST;
         loopSh_ff <= vdc_pkg::LOOP_RST;
         fbIntSh_ff <= vdc_pkg::FB_INT_RST;
         fbAuxSh_ff <= vdc_pkg::FB_AUX_RST;
         pdRstSh_ff <= vdc_pkg::PD_RESET_RST;
         pdRatioSh_ff <= vdc_pkg::PD_RATIO_RST;
         chSrcSh_ff <= vdc_pkg::CH_SRC_RST;
      end else if (wrAccept) begin
         unique case (idx)
            vdc_pkg::IDX_CONTROL: ctrlSh_ff <= avs_writedata[7:0];
            vdc_pkg::IDX_LOOP: loopSh_ff <= avs_writedata[7:0];
            vdc_pkg::IDX_FB_INT: fbIntSh_ff <= avs_writedata[7:0];
            vdc_pkg::IDX_FB_AUX: begin
               if (avs_byteenable[1]) begin
                  fbAuxSh_ff <= avs_writedata[11:0];
               end
            end
            vdc_pkg::IDX_PD_RESET: pdRstSh_ff <= avs_writedata[7:0];
            vdc_pkg::IDX_PD_RATIO: pdRatioSh_ff <= avs_writedata[7:0];
            vdc_pkg::IDX_CH_SRC: chSrcSh_ff <= avs_writedata[1:0];
            default: ;
         endcase
      end
   end

   // Nothing staged reaches the logic until the update strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrlAct_ff <= vdc_pkg::CONTROL_RST;
         loopAct_ff <= vdc_pkg::LOOP_RST[vdc_pkg::LOOP_LSB +: 2];
         fbIntAct_ff <= vdc_pkg::FB_INT_RST;
         fbAuxAct_ff <= vdc_pkg::FB_AUX_RST;
         pdRstAct_ff <= vdc_pkg::PD_RESET_RST;
         pdRatioAct_ff <= vdc_pkg::PD_RATIO_RST;
         chSrcAct_ff <= vdc_pkg::CH_SRC_RST;
      end else if (commit) begin
         ctrlAct_ff <= ctrlSh_ff;
         loopAct_ff <= loopSh_ff[vdc_pkg::LOOP_LSB +: 2];
         fbIntAct_ff <= fbIntSh_ff;
         fbAuxAct_ff <= fbAuxSh_ff;
         pdRstAct_ff <= pdRstSh_ff;
         pdRatioAct_ff <= pdRatioSh_ff;
         chSrcAct_ff <= chSrcSh_ff;
      end
   end

   // ********************
   // Calibration sequencer
   // ********************
   vdc_pkg::vdc_cal_state_t state_ff;
   logic calReq;
   logic ungated;
   logic refOk;
   logic bandStart;
   logic bandDone;
   logic [19:0] fbTotal;
   logic firstPend_ff;
   logic loop2Sub_ff;

   // Start on presetLoadDone or on a 0-to-1 commit of the bit; the device never clears it
   assign calReq = presetLoadDone
      || (commit && ctrlSh_ff[vdc_pkg::CTRL_CAL_BIT]
      && !ctrlAct_ff[vdc_pkg::CTRL_CAL_BIT]);
   assign fbTotal = 20'(fbIntAct_ff) * 20'(fbAuxAct_ff);
   // Slow loop-1 references sit below the loss flag threshold
   assign ungated = (loopAct_ff == vdc_pkg::LOOP_ONE)
      && (fbTotal >= vdc_pkg::UNGATED_MIN_TOTAL);
   assign refOk = ungated || !refLost;
   assign bandStart = (state_ff == vdc_pkg::CAL_WAIT_REF) && refOk && refEdge;

   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= vdc_pkg::CAL_IDLE;
      end else begin
         unique case (state_ff)
            vdc_pkg::CAL_IDLE: begin
               if (calReq) begin
                  state_ff <= vdc_pkg::CAL_WAIT_REF;
               end
            end
            vdc_pkg::CAL_WAIT_REF: begin
               if (bandStart) begin
                  state_ff <= vdc_pkg::CAL_RUN;
               end
            end
            vdc_pkg::CAL_RUN: begin
               if (bandDone) begin
                  state_ff <= vdc_pkg::CAL_IDLE;
               end
            end
            default: state_ff <= vdc_pkg::CAL_IDLE;
         endcase
      end
   end

   assign calBusy = (state_ff != vdc_pkg::CAL_IDLE);

   vdc_band_search #(
      .CAL_CYCLES(CAL_CYCLES)
   ) u_band (
      .clock(clock),
      .rst(rst),
      .start(bandStart),
      .pfdTick(pfdTick),
      .fbFaster(fbFaster),
      .band(band),
      .done(bandDone)
   );

   // First calibration after any reset keeps the distribution in sync
   always_ff @(posedge clock) begin
      if (rst || pllReset) begin
         firstPend_ff <= 1'b1;
      end else if (bandDone) begin
         firstPend_ff <= 1'b0;
      end
   end

   assign chanSyncHold = firstPend_ff && calBusy;

   // Loop 2 loses its feedback while dividers are synced, so loop 0 stands in
   always_ff @(posedge clock) begin
      if (rst) begin
         loop2Sub_ff <= 1'b0;
      end else if (bandDone && loopAct_ff == vdc_pkg::LOOP_TWO) begin
         loop2Sub_ff <= 1'b1;
      end else if (commit) begin
         loop2Sub_ff <= 1'b0;
      end
   end

   always_comb begin
      loopMode = vdc_pkg::LOOP_ZERO;
      if (loopAct_ff == vdc_pkg::LOOP_ONE) begin
         loopMode = vdc_pkg::LOOP_ONE;
      end else if (loopAct_ff == vdc_pkg::LOOP_TWO && !calBusy && !loop2Sub_ff) begin
         loopMode = vdc_pkg::LOOP_TWO;
      end
   end

   assign calFbCascade = calBusy && (loopAct_ff == vdc_pkg::LOOP_ONE);

   // ********************
   // Post dividers
   // ********************
   logic [1:0] divTicks;
   logic [1:0] divOns;
   logic calRun;

   assign calRun = (state_ff == vdc_pkg::CAL_RUN);

   for (genvar i = 0; i < 2; i++) begin : g_div
      vdc_post_divider u_div (
         .clock(clock),
         .rst(rst),
         .oscTick(oscTick),
         .syncReset(pdRstAct_ff[4 * i] || calRun),
         .ratio(pdRatioAct_ff[4 * i +: 4]),
         .divTick(divTicks[i]),
         .powered(divOns[i])
      );
   end

   assign divATick = divTicks[0];
   assign divBTick = divTicks[1];
   assign divAOn = divOns[0];
   assign divBOn = divOns[1];

   // Channel dividers one and two may take either source
   always_comb begin
      chanTick = {4{divATick}};
      if (chSrcAct_ff[0]) begin
         chanTick[1] = divBTick;
      end
      if (chSrcAct_ff[1]) begin
         chanTick[2] = divBTick;
      end
      if (chanSyncHold) begin
         chanTick = 4'h0;
      end
   end

   assign zdTick = divATick && !chanSyncHold;

   // ********************
   // Read path
   // ********************
   always_comb begin
      rdByte = 8'h00;
      if (aligned) begin
         unique case (idx)
            vdc_pkg::IDX_STATUS: rdByte[vdc_pkg::STAT_BUSY_BIT] = calBusy;
            vdc_pkg::IDX_CONTROL: rdByte = ctrlSh_ff;
            vdc_pkg::IDX_LOOP: rdByte = loopSh_ff;
            vdc_pkg::IDX_FB_INT: rdByte = fbIntSh_ff;
            vdc_pkg::IDX_PD_RESET: rdByte = pdRstSh_ff;
            vdc_pkg::IDX_PD_RATIO: rdByte = pdRatioSh_ff;
            vdc_pkg::IDX_CH_SRC: rdByte = {6'h00, chSrcSh_ff};
            default: rdByte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !ack_ff) begin
         if (aligned && idx == vdc_pkg::IDX_FB_AUX) begin
            avs_readdata <= {20'h00000, fbAuxSh_ff};
         end else begin
            avs_readdata <= {24'h000000, rdByte};
         end
      end
   end

   // ********************
   // Checks
   // ********************
   chk_commit_only: assert property (@(posedge clock) disable iff (rst)
      !$past(commit) |-> pdRstAct_ff == $past(pdRstAct_ff))
      else $error("Divider reset changed without update strobe");
   chk_div_reset: assert property (@(posedge clock) disable iff (rst)
      calRun |=> !divATick && !divBTick)
      else $error("Post divider ran during calibration");
   chk_ref_gate: assert property (@(posedge clock) disable iff (rst)
      state_ff == vdc_pkg::CAL_WAIT_REF && refLost && !ungated
      |=> state_ff == vdc_pkg::CAL_WAIT_REF)
      else $error("Calibration left wait with reference lost");
   chk_ungated_go: assert property (@(posedge clock) disable iff (rst)
      state_ff == vdc_pkg::CAL_WAIT_REF && ungated && refEdge
      |=> state_ff == vdc_pkg::CAL_RUN ##1 band == 8'h80)
      else $error("Ungated loop 1 calibration did not start");
   chk_preset_start: assert property (@(posedge clock) disable iff (rst)
      presetLoadDone && !calBusy |=> calBusy && state_ff == vdc_pkg::CAL_WAIT_REF)
      else $error("Preset load did not start calibration");
   chk_bit_kept: assert property (@(posedge clock) disable iff (rst)
      $fell(calBusy) |-> ctrlAct_ff[3] == $past(ctrlAct_ff[3], 2))
      else $error("Calibrate bit changed by the device");
   chk_busy_status: assert property (@(posedge clock) disable iff (rst)
      avs_read && !avs_waitrequest && avs_address == 11'h080
      |-> avs_readdata[2] == $past(calBusy))
      else $error("Status bit does not show calibration");
   chk_first_hold: assert property (@(posedge clock) disable iff (rst)
      firstPend_ff && calBusy |-> chanTick == 4'h0 && !zdTick)
      else $error("Channels ran during first calibration");
   chk_loop2_sub: assert property (@(posedge clock) disable iff (rst)
      loopAct_ff == 2'h2 && (calBusy || loop2Sub_ff) |-> loopMode == 2'h0)
      else $error("Loop 2 not replaced by loop 0");
   chk_loop_zero: assert property (@(posedge clock) disable iff (rst)
      loopAct_ff == 2'h0 |-> loopMode == 2'h0)
      else $error("Loop field zero selected another loop");
   chk_cascade: assert property (@(posedge clock) disable iff (rst)
      calBusy && loopAct_ff == 2'h1 |-> calFbCascade)
      else $error("Loop 1 calibration lacks cascade feedback");
   chk_feed_a: assert property (@(posedge clock) disable iff (rst)
      !chanSyncHold |-> chanTick[0] == divATick && chanTick[3] == divATick)
      else $error("Channel zero or three not fed by divider A");
endmodule // vdc_cal_ctrl
`default_nettype wire

// File: tb/test_vdc_cal_ctrl.sv
// Self-checking bench for the divider and calibration controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin errCount++; \
   $display("wrong value at %0t: %s", $time, m); end end
module test_vdc_cal_ctrl;
   // ********************
   // Stimulus and design
   // ********************
   logic clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [10:0] avs_address = 11'h000;
   logic [31:0] avs_writedata = 32'h0;
   logic oscTick = 1'b0, refLost = 1'b0, fbFaster = 1'b0;
   logic presetLoadDone = 1'b0, pllReset = 1'b0;
   logic pfdTick = 1'b1, refEdge = 1'b1, halfRate = 1'b0, fixFb = 1'b0, fbFix = 1'b0;
   logic [31:0] avs_readdata;
   logic [7:0] band;
   logic [1:0] loopMode;
   logic [3:0] chanTick;
   logic avs_waitrequest, calFbCascade, calBusy, divATick, divBTick;
   logic divAOn, divBOn, zdTick, chanSyncHold;
   logic [31:0] expq[$];
   int errCount = 0, checked = 0, n, m, b, i;
   logic [7:0] rt[4] = '{8'h1b, 8'h5c, 8'hf0, 8'h44};
   // Short count keeps the run brief: eight ticks per trial
   vdc_cal_ctrl #(.CAL_CYCLES(64)) dut (.clock(clock), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .oscTick(oscTick), .pfdTick(pfdTick),
      .refEdge(refEdge), .refLost(refLost), .fbFaster(fbFaster),
      .presetLoadDone(presetLoadDone), .pllReset(pllReset), .band(band),
      .loopMode(loopMode), .calFbCascade(calFbCascade), .calBusy(calBusy),
      .divATick(divATick), .divBTick(divBTick), .divAOn(divAOn), .divBOn(divBOn),
      .chanTick(chanTick), .zdTick(zdTick), .chanSyncHold(chanSyncHold));
   initial begin
      forever #50 clock = ~clock;
   end
   // One seed serves every random input
   initial begin
      void'($urandom(44));
      forever @(posedge clock) begin
         oscTick <= 1'($urandom);
         fbFaster <= fixFb ? fbFix : 1'($urandom);
         pfdTick <= halfRate ? !pfdTick : 1'b1;
      end
   end
   // Oldest expected read value against each accepted read
   always @(posedge clock) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         `CHK(avs_readdata, expq.pop_front(), "read data")
      end
   end
   task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] d);
      @(posedge clock);
      avs_address <= {idx, 2'h0};
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] idx, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, idx, 32'h0);
   endtask
   task automatic upd();
      bus(1'b1, vdc_pkg::IDX_UPDATE, 32'h1);
   endtask
   // Two edges first: a tick launched before the strobe must drain
   task automatic ticks(input int c);
      repeat (2) @(posedge clock);
      n = 0;
      m = 0;
      b = 0;
      repeat (c) @(posedge clock) begin
         n += divATick;
         b += divBTick;
         m += (|chanTick || zdTick);
      end
   endtask
   // Bounded wait for the busy flag to reach a level
   task automatic waitBusy(input logic v, input int c);
      for (i = 0; i < c && calBusy !== v; i++) @(posedge clock);
   endtask
   task automatic tally_and_finish();
      if (errCount == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #(100 * 6000);
      errCount++;
      tally_and_finish();
   end
   // ********************
   // Scenarios
   // ********************
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      rd(vdc_pkg::IDX_PD_RATIO, 32'h44);
      rd(vdc_pkg::IDX_STATUS, 32'h0);
      rd(9'h1ff, 32'h0);
      `CHK(loopMode, 2'h0, "loop at reset")
      foreach (rt[k]) begin
         bus(1'b1, vdc_pkg::IDX_PD_RATIO, {24'h0, rt[k]});
         rd(vdc_pkg::IDX_PD_RATIO, {24'h0, rt[k]});
         if (k == 0) `CHK({divAOn, divBOn}, 2'b11, "ratio before update")
         upd();
         repeat (2) @(posedge clock);
         `CHK(divAOn, rt[k][3:0] >= 4'h2 && rt[k][3:0] <= 4'hb, "divider a")
         `CHK(divBOn, rt[k][7:4] >= 4'h2 && rt[k][7:4] <= 4'hb, "divider b")
      end
      // Both dividers reset together, then released together
      bus(1'b1, vdc_pkg::IDX_PD_RESET, 32'h11);
      upd();
      ticks(30);
      `CHK({n, b}, 64'h0, "held divider ticked")
      bus(1'b1, vdc_pkg::IDX_PD_RESET, 32'h0);
      upd();
      ticks(40);
      `CHK(n != 0, 1'b1, "released divider silent")
      `CHK(b, n, "divider b out of step")
      `CHK(m, n, "channels not fed by divider a")
      // First calibration, held back by a lost reference
      refLost <= 1'b1;
      bus(1'b1, vdc_pkg::IDX_CONTROL, 32'h8);
      upd();
      @(posedge clock);
      `CHK({calBusy, chanSyncHold}, 2'b11, "first calibration start")
      ticks(40);
      `CHK(m, 0, "channels ran while held")
      rd(vdc_pkg::IDX_STATUS, 32'h4);
      refLost <= 1'b0;
      ticks(60);
      `CHK({n, calBusy}, {32'h0, 1'b1}, "calibration run")
      waitBusy(1'b0, 20);
      `CHK({calBusy, chanSyncHold}, 2'b00, "calibration end")
      rd(vdc_pkg::IDX_CONTROL, 32'h8);
      upd();
      repeat (2) @(posedge clock);
      `CHK(calBusy, 1'b0, "restart without clear")
      // Loop two is calibrated as loop zero
      bus(1'b1, vdc_pkg::IDX_FB_INT, 32'h32);
      bus(1'b1, vdc_pkg::IDX_LOOP, 32'h4);
      bus(1'b1, vdc_pkg::IDX_CONTROL, 32'h0);
      upd();
      @(posedge clock);
      `CHK(loopMode, 2'h2, "loop two select")
      bus(1'b1, vdc_pkg::IDX_CONTROL, 32'h8);
      upd();
      @(posedge clock);
      `CHK({calBusy, chanSyncHold}, 2'b10, "later calibration")
      waitBusy(1'b0, 100);
      `CHK({calBusy, loopMode}, 3'h0, "loop after calibration")
      // Loop one with total 512 ignores the lost flag but still waits for an edge
      refLost <= 1'b1;
      refEdge <= 1'b0;
      fixFb <= 1'b1;
      fbFix <= 1'b1;
      bus(1'b1, vdc_pkg::IDX_LOOP, 32'h2);
      bus(1'b1, vdc_pkg::IDX_FB_INT, 32'h80);
      bus(1'b1, vdc_pkg::IDX_CONTROL, 32'h0);
      upd();
      bus(1'b1, vdc_pkg::IDX_CONTROL, 32'h8);
      upd();
      repeat (3) @(posedge clock);
      `CHK(calFbCascade, 1'b1, "cascade feedback")
      // Longer than a whole calibration: no edge, no start
      repeat (80) @(posedge clock);
      rd(vdc_pkg::IDX_STATUS, 32'h4);
      refEdge <= 1'b1;
      waitBusy(1'b0, 100);
      `CHK(calBusy, 1'b0, "ungated calibration")
      `CHK(band, 8'h00, "band with fast feedback")
      bus(1'b1, vdc_pkg::IDX_LOOP, 32'h4);
      upd();
      @(posedge clock);
      `CHK(loopMode, 2'h2, "back to loop two")
      // Preset load after a loop reset, phase detector at half rate
      refLost <= 1'b0;
      fbFix <= 1'b0;
      halfRate <= 1'b1;
      pllReset <= 1'b1;
      @(posedge clock) pllReset <= 1'b0;
      presetLoadDone <= 1'b1;
      @(posedge clock) presetLoadDone <= 1'b0;
      @(posedge clock);
      `CHK({calBusy, chanSyncHold}, 2'b11, "preset calibration")
      repeat (100) @(posedge clock);
      `CHK(calBusy, 1'b1, "half-rate calibration too short")
      waitBusy(1'b0, 100);
      `CHK({calBusy, chanSyncHold}, 2'b00, "preset calibration end")
      `CHK(band, 8'hff, "band with slow feedback")
      tally_and_finish();
   end
endmodule // test_vdc_cal_ctrl
`default_nettype wire
